/* core/bank_mapper_pkg.sv */
// package for the emulation bank mapper: register map, field layouts, enumerations
// assumes a single pclk domain and an apb slave with 32-bit data
// Behaviour
// - the extended address is the current bank number in four bits above the 16-bit cpu address, or zero when the access is not banked.
// - up to sixteen banks of 64 kilobytes each form one linear space.
// - emulator rom regions serve reads from emulation memory and block cpu writes to it.
// - emulator ram regions serve both reads and writes from emulation memory.
// - with write protect enabled a cpu write into emulator rom raises an error event, rom only.
// - the bank-select input lines are sampled to find the active bank.
// - four bank modes exist: none, 64k, 32k in the lower half and 32k in the upper half.
// - bank zero is not a valid bank in either 32k mode.
// - banking applies only between a lower and upper limit, with 0 and ffff meaning no limit.
// - in snoop mode the bank number comes from the masked bits of the byte written to the bank port.
// - only bank masks with contiguous set bits are accepted.
// - the bank value is kept from writes; a cpu read at the configured read address gets no emulation read and no bank value.
package bank_mapper_pkg;
  localparam int unsigned cpu_aw = 16;
  localparam int unsigned bank_w = 4;
  localparam int unsigned ext_aw = cpu_aw + bank_w;
  localparam int unsigned map_blocks = 16;
  localparam int unsigned map_blk_lsb = 12;

  // register byte offsets
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_limits = 8'h04;
  localparam logic [7:0] off_port = 8'h08;
  localparam logic [7:0] off_map = 8'h0c;
  localparam logic [7:0] off_status = 8'h10;
  localparam logic [7:0] off_int_status = 8'h14;
  localparam logic [7:0] off_int_mask = 8'h18;

  // ctrl fields, then port word and bank mask field positions
  localparam int unsigned ctrl_mode_lsb = 0;
  localparam int unsigned ctrl_src_bit = 2;
  localparam int unsigned ctrl_wp_bit = 3;
  localparam int unsigned port_mask_lsb = 16;
  localparam int unsigned port_rd_lsb = 16;

  // interrupt bits
  localparam int unsigned int_wp_err = 0;
  localparam int unsigned int_bad_mask = 1;
  localparam int unsigned int_bad_bank = 2;
  localparam int unsigned int_w = 3;

  localparam logic [cpu_aw-1:0] half_msb_mask = 16'h8000;
  localparam logic [cpu_aw-1:0] limit_hi_rst = 16'hffff;
  localparam logic [31:0] zero_word = 32'h0000_0000;

  typedef enum logic [1:0] {mode_none, mode_64k, mode_32k_low, mode_32k_high} bank_mode_t;
  typedef enum logic [1:0] {map_target, map_rom, map_ram, map_rsvd} map_kind_t;
endpackage : bank_mapper_pkg

/* core/bank_extract.sv */
// mask check and bank extraction from a snooped byte
// assumes mask and byte come from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module bank_extract
  import bank_mapper_pkg::*;
(
  input wire logic [7:0] data_byte,
  input wire logic [7:0] mask,
  output logic [bank_w-1:0] bank,
  output logic mask_ok
);
  logic [7:0] masked;
  logic [7:0] shifted;
  logic [3:0] lsb_pos;
  logic [7:0] norm_mask;

  // lowest set bit by priority scan
  always_comb begin
    lsb_pos = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (mask[i]) begin
        lsb_pos = 4'(i);
      end
    end
  end

  // contiguous iff mask shifted to bit 0 plus one is a power of two
  assign masked = data_byte & mask;
  assign shifted = masked >> lsb_pos;
  assign norm_mask = mask >> lsb_pos;
  assign mask_ok = (mask != 8'h00) && (((norm_mask + 8'h01) & norm_mask) == 8'h00);
  assign bank = shifted[bank_w-1:0];
endmodule : bank_extract
`default_nettype wire

/* core/bank_mapper.sv */
// emulation bank mapper: classifies cpu accesses, tracks the active bank, forms 20-bit addresses
// assumes cpu bus signals are synchronous to pclk; bank-select pins are asynchronous
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module bank_mapper
  import bank_mapper_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic [cpu_aw-1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic bank_sel_in_bit0,
  input wire logic bank_sel_in_bit1,
  input wire logic bank_sel_in_bit2,
  input wire logic bank_sel_in_bit3,
  input wire logic bank_width_select_pin,
  output logic [ext_aw-1:0] ext_addr,
  output logic to_target,
  output logic emu_rd,
  output logic emu_wr,
  output logic bank_valid,
  output logic wp_error,
  output logic irq
);
  // configuration registers
  logic [1:0] mode_reg;
  logic src_snoop;
  logic wp_en;
  logic [cpu_aw-1:0] limit_lo;
  logic [cpu_aw-1:0] limit_hi;
  logic [cpu_aw-1:0] port_wr_addr;
  logic [cpu_aw-1:0] port_rd_addr;
  logic [7:0] port_mask;
  logic [2*map_blocks-1:0] map_cfg;
  logic [int_w-1:0] int_status;
  logic [int_w-1:0] int_mask;

  // bank state
  logic [7:0] bank_latch;
  logic [bank_w-1:0] snoop_bank;
  logic [bank_w-1:0] pin_sync1;
  logic [bank_w-1:0] pin_sync2;
  logic wsel_sync1;
  logic wsel_sync2;

  // apb decode
  wire apb_access = psel && penable;
  wire apb_wr = apb_access && pwrite;
  wire hit_ctrl = (paddr == off_ctrl);
  wire hit_limits = (paddr == off_limits);
  wire hit_port = (paddr == off_port);
  wire hit_map = (paddr == off_map);
  wire hit_status = (paddr == off_status);
  wire hit_int_status = (paddr == off_int_status);
  wire hit_int_mask = (paddr == off_int_mask);
  wire hit_any = hit_ctrl | hit_limits | hit_port | hit_map | hit_status | hit_int_status
                 | hit_int_mask;

  // bank extraction from the snooped byte
  wire [bank_w-1:0] ext_bank;
  wire mask_ok;
  bank_extract u_extract (
    .data_byte(bank_latch),
    .mask(port_mask),
    .bank(ext_bank),
    .mask_ok(mask_ok)
  );

  // cpu access decode
  bank_mode_t mode;
  assign mode = bank_mode_t'(mode_reg);
  wire [bank_w-1:0] pin_bank = pin_sync2;
  wire [bank_w-1:0] cur_bank = src_snoop ? snoop_bank : pin_bank;
  wire in_limits = (cpu_addr >= limit_lo) && (cpu_addr <= limit_hi);
  wire upper_half = (cpu_addr & half_msb_mask) != 16'h0000;
  wire in_bank_half = (mode == mode_64k) ||
                      (mode == mode_32k_low && !upper_half) ||
                      (mode == mode_32k_high && upper_half);
  wire banked = (mode != mode_none) && in_bank_half && in_limits;
  wire is_32k = (mode == mode_32k_low) || (mode == mode_32k_high);
  wire bank_ok = !(is_32k && cur_bank == 4'h0);
  wire [bank_w-1:0] eff_bank = banked ? cur_bank : 4'h0;
  wire [3:0] blk_idx = cpu_addr[cpu_aw-1:map_blk_lsb];
  wire [1:0] blk_kind_raw = map_cfg[2*blk_idx +: 2];
  map_kind_t blk_kind;
  assign blk_kind = map_kind_t'(blk_kind_raw);
  wire is_rom = (blk_kind == map_rom);
  wire is_ram = (blk_kind == map_ram);
  wire snoop_hit = cpu_valid && cpu_write && (cpu_addr == port_wr_addr);
  wire rd_back_hit = cpu_valid && !cpu_write && (cpu_addr == port_rd_addr);
  wire rom_write = cpu_valid && cpu_write && is_rom;
  wire wp_event = rom_write && wp_en;
  wire bad_bank_event = cpu_valid && banked && !bank_ok;
  wire mask_event = snoop_hit && !mask_ok;

  // interrupt set/clear: set wins over a simultaneous write-one clear
  wire [int_w-1:0] int_set = {bad_bank_event, mask_event, wp_event};
  wire [int_w-1:0] int_clr = (apb_wr && hit_int_status) ? pwdata[int_w-1:0] : 3'h0;
  wire [int_w-1:0] next_int_status = (int_status & ~int_clr) | int_set;

  // read mux
  wire [31:0] status_word = {16'h0000, 7'h00, wsel_sync2, 3'h0, mask_ok, cur_bank};
  wire [31:0] rd_mux =
    hit_ctrl ? {28'h0000000, wp_en, src_snoop, mode_reg} :
    hit_limits ? {limit_hi, limit_lo} :
    hit_port ? {port_rd_addr, port_wr_addr} :
    hit_map ? map_cfg :
    hit_status ? status_word :
    hit_int_status ? {29'h0000000, int_status} :
    hit_int_mask ? {29'h0000000, int_mask} :
    zero_word;

  // apb answers in the access cycle; pready registered for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= zero_word;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : zero_word;
    end
  end

  // writes take effect only at the completing edge
  wire do_wr = apb_wr && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 2'h0;
      src_snoop <= 1'b0;
      wp_en <= 1'b0;
    end else if (do_wr && hit_ctrl) begin
      mode_reg <= pwdata[ctrl_mode_lsb +: 2];
      src_snoop <= pwdata[ctrl_src_bit];
      wp_en <= pwdata[ctrl_wp_bit];
    end
  end

  // reset limits give an unrestricted bank area
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_lo <= 16'h0000;
      limit_hi <= limit_hi_rst;
    end else if (do_wr && hit_limits) begin
      limit_lo <= pwdata[cpu_aw-1:0];
      limit_hi <= pwdata[31:cpu_aw];
    end
  end

  // port word: snooped write address low, read-back address high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_wr_addr <= 16'h0000;
      port_rd_addr <= 16'h0000;
    end else if (do_wr && hit_port) begin
      port_wr_addr <= pwdata[cpu_aw-1:0];
      port_rd_addr <= pwdata[31:port_rd_lsb];
    end
  end

  // a gapped or empty mask is refused and the old mask kept
  logic [3:0] new_lsb;
  wire [7:0] new_mask = pwdata[port_mask_lsb +: 8];
  wire [7:0] new_norm = new_mask >> new_lsb;
  always_comb begin
    new_lsb = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (new_mask[i]) begin
        new_lsb = 4'(i);
      end
    end
  end
  wire mask_write_ok = (new_mask != 8'h00) && (((new_norm + 8'h01) & new_norm) == 8'h00);

  // bank mask shares the int_mask word, upper bits, to save a register slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_mask <= 8'h0f;
      int_mask <= 3'h0;
    end else if (do_wr && hit_int_mask) begin
      int_mask <= pwdata[int_w-1:0];
      if (mask_write_ok) begin
        port_mask <= pwdata[port_mask_lsb +: 8];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_cfg <= 32'h0000_0000;
    end else if (do_wr && hit_map) begin
      map_cfg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= 3'h0;
    end else begin
      int_status <= next_int_status;
    end
  end

  // snooped bank byte and derived bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_latch <= 8'h00;
      snoop_bank <= 4'h0;
    end else begin
      if (snoop_hit) begin
        bank_latch <= cpu_wdata;
      end
      snoop_bank <= mask_ok ? ext_bank : snoop_bank;
    end
  end

  // two-flop synchronisers for the asynchronous pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1 <= 4'h0;
      pin_sync2 <= 4'h0;
      wsel_sync1 <= 1'b0;
      wsel_sync2 <= 1'b0;
    end else begin
      pin_sync1 <= {bank_sel_in_bit3, bank_sel_in_bit2, bank_sel_in_bit1, bank_sel_in_bit0};
      pin_sync2 <= pin_sync1;
      wsel_sync1 <= bank_width_select_pin;
      wsel_sync2 <= wsel_sync1;
    end
  end

  // registered access outputs, one cycle after the cpu cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_addr <= 20'h00000;
      to_target <= 1'b0;
      emu_rd <= 1'b0;
      emu_wr <= 1'b0;
      bank_valid <= 1'b0;
      wp_error <= 1'b0;
      irq <= 1'b0;
    end else begin
      ext_addr <= {eff_bank, cpu_addr};
      to_target <= cpu_valid && !is_rom && !is_ram;
      emu_rd <= cpu_valid && !cpu_write && (is_rom || is_ram) && !rd_back_hit;
      emu_wr <= cpu_valid && cpu_write && is_ram;
      bank_valid <= !banked || bank_ok;
      wp_error <= wp_event;
      irq <= (next_int_status & int_mask) != 3'h0;
    end
  end
endmodule : bank_mapper
`default_nettype wire

/* bench/bank_mapper_properties.sv */
// port assertions for the bank mapper
// assumes one pclk domain and presetn as asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module bank_mapper_checker
  import bank_mapper_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic pready,
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic [cpu_aw-1:0] cpu_addr,
  input wire logic [ext_aw-1:0] ext_addr,
  input wire logic to_target,
  input wire logic emu_rd,
  input wire logic emu_wr,
  input wire logic bank_valid,
  input wire logic wp_error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a transfer: setup, then one zero-wait access cycle
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_answer;
    psel && penable && pready;
  endsequence
  a_apb_zero_wait: assert property (apb_setup |=> apb_answer) else $error("no apb answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_ext_addr_low: assert property (cpu_valid |=> ext_addr[15:0] == $past(cpu_addr))
    else $error("low address wrong");
  a_one_route: assert property ($onehot0({to_target, emu_rd, emu_wr}))
    else $error("two routes at once");
  a_idle_quiet: assert property (!cpu_valid |=> !(to_target || emu_rd || emu_wr || wp_error))
    else $error("route without access");
  a_emu_rd_read: assert property (emu_rd |-> $past(cpu_valid && !cpu_write))
    else $error("emu read on write");
  a_wp_is_write: assert property (wp_error |-> !emu_wr && $past(cpu_valid && cpu_write))
    else $error("bad protect event");
  a_bank0_invalid: assert property (!bank_valid |-> ext_addr[19:16] == 4'h0)
    else $error("invalid bank not zero");
endmodule : bank_mapper_checker
`default_nettype wire

/* bench/bank_target_model.sv */
// target side: port latch driving the bank-select pins, plus the width strap
// assumes the cpu writes the bank port at port_addr
`timescale 1ns/1ns
`default_nettype none
module bank_target_model #(parameter logic [15:0] port_addr = 16'h0008) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [3:0] bank_pins,
  output logic width_pin
);
  logic [3:0] latch;
  logic driven;
  // port lines float until first written, so they wander instead of holding a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= 4'h0;
      driven <= 1'b0;
    end else if (cpu_valid && cpu_write && cpu_addr == port_addr) begin
      latch <= cpu_wdata[3:0];
      driven <= 1'b1;
    end else if (!driven) begin
      latch <= ~latch;
    end
  end
  assign bank_pins = latch;
  assign width_pin = 1'b0; // strapped low: 64k wiring
endmodule : bank_target_model
`default_nettype wire

/* bench/emulation_bank_mapper_tb_top.sv */
// self-checking bench: apb set-up of the mapper, then cpu accesses
// assumes the target model drives the bank pins from its port latch
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module emulation_bank_mapper_tb_top import bank_mapper_pkg::*; ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_valid = 0, cpu_write = 0;
  logic [7:0] paddr = 8'h00, cpu_wdata = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] cpu_addr = 16'h0;
  logic [19:0] ext_addr;
  logic [3:0] pins;
  logic pready, pslverr, err, to_target, emu_rd, emu_wr, bank_valid, wp_error, irq, wpin;
  int n_mismatch = 0, total_checks = 0;
  always #4 pclk = ~pclk;
  bank_mapper dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_valid(cpu_valid), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .bank_sel_in_bit0(pins[0]), .bank_sel_in_bit1(pins[1]),
    .bank_sel_in_bit2(pins[2]), .bank_sel_in_bit3(pins[3]), .bank_width_select_pin(wpin),
    .ext_addr(ext_addr), .to_target(to_target), .emu_rd(emu_rd), .emu_wr(emu_wr),
    .bank_valid(bank_valid), .wp_error(wp_error), .irq(irq));
  bank_target_model tgt (.pclk(pclk), .presetn(presetn), .cpu_valid(cpu_valid),
    .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .bank_pins(pins),
    .width_pin(wpin));
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i == 20) begin n_mismatch++; final_report(); end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // one cpu access; outputs are looked at one cycle later
  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    {cpu_valid, cpu_write, cpu_addr, cpu_wdata} <= {1'b1, w, a, d};
    @(posedge pclk) cpu_valid <= 1'b0;
    #1;
  endtask : cpu
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, off_limits, 0); `CHK("limits", 32'hffff_0000, rd)
    apb(0, 8'h40, 0); `CHK("unmapped", {1'b1, 32'h0}, {err, rd})
    apb(1, off_map, 32'h0000_0024); // block 1 rom, block 2 ram
    apb(1, off_ctrl, 32'h0000_0009);
    apb(1, off_int_mask, 32'h0038_0007);
    cpu(0, 16'h1000, 0); `CHK("rom rd", 3'b010, {to_target, emu_rd, emu_wr})
    cpu(1, 16'h1004, 8'h11); `CHK("rom wr", 4'b0001, {to_target, emu_rd, emu_wr, wp_error})
    apb(0, off_int_status, 0); `CHK("wp irq", {32'h1, 1'b1}, {rd, irq})
    apb(1, off_int_mask, 32'h0038_0006);
    apb(1, off_port, 32'h0008_0008); `CHK("masked", 1'b0, irq)
    apb(1, off_int_status, 32'h1);
    apb(1, off_int_mask, 32'h0038_0007);
    apb(0, off_int_status, 0); `CHK("cleared", {32'h0, 1'b0}, {rd, irq})
    cpu(1, 16'h2000, 8'h5a); `CHK("ram wr", 3'b001, {to_target, emu_rd, emu_wr})
    cpu(0, 16'h2001, 0); `CHK("ram rd", 3'b010, {to_target, emu_rd, emu_wr})
    cpu(0, 16'h0100, 0); `CHK("target", 3'b100, {to_target, emu_rd, emu_wr})
    apb(1, off_ctrl, 32'h0000_0001);
    cpu(1, 16'h1000, 8'h22); `CHK("wp off", 2'b00, {emu_wr, wp_error})
    cpu(1, 16'h0008, 8'h05); // pins come from the target latch, after the synchroniser
    repeat (4) @(posedge pclk);
    cpu(0, 16'h2345, 0); `CHK("pin bank", 20'h5_2345, ext_addr)
    apb(1, off_ctrl, 32'h0000_0005);
    cpu(1, 16'h0008, 8'h50);
    repeat (2) @(posedge pclk);
    cpu(0, 16'h2345, 0); `CHK("snoop bank", 20'h2_2345, ext_addr)
    apb(0, off_status, 0); `CHK("status", 9'h012, rd[8:0])
    apb(1, off_int_mask, 32'h0058_0007); // gapped mask must be refused
    cpu(1, 16'h0008, 8'h28);
    repeat (2) @(posedge pclk);
    cpu(0, 16'h3fff, 0); `CHK("gap kept", 20'h5_3fff, ext_addr)
    apb(1, off_limits, 32'hffff_4000);
    cpu(0, 16'h3fff, 0); `CHK("below lim", 20'h0_3fff, ext_addr)
    cpu(0, 16'h4000, 0); `CHK("in lim", 20'h5_4000, ext_addr)
    apb(1, off_limits, 32'hffff_0000);
    apb(1, off_ctrl, 32'h0000_0006);
    cpu(1, 16'h0008, 8'h00);
    repeat (2) @(posedge pclk);
    cpu(0, 16'h1000, 0); `CHK("bank0 low", 1'b0, bank_valid)
    cpu(0, 16'h9000, 0); `CHK("low hi half", {1'b1, 20'h0_9000}, {bank_valid, ext_addr})
    apb(0, off_int_status, 0); `CHK("bank0 int", 3'b100, rd[2:0])
    apb(1, off_ctrl, 32'h0000_0007);
    cpu(1, 16'h0008, 8'h18);
    repeat (2) @(posedge pclk);
    cpu(0, 16'h1000, 0); `CHK("high lo half", 20'h0_1000, ext_addr)
    cpu(0, 16'h9000, 0); `CHK("high hi half", 20'h3_9000, ext_addr)
    apb(1, off_ctrl, 32'h0000_0004);
    cpu(0, 16'h9000, 0); `CHK("no banks", 20'h0_9000, ext_addr)
    final_report();
  end
endmodule : emulation_bank_mapper_tb_top
bind bank_mapper bank_mapper_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pslverr(pslverr), .pready(pready), .cpu_valid(cpu_valid),
  .cpu_write(cpu_write), .cpu_addr(cpu_addr), .ext_addr(ext_addr), .to_target(to_target),
  .emu_rd(emu_rd), .emu_wr(emu_wr), .bank_valid(bank_valid), .wp_error(wp_error));
`default_nettype wire
